//--- core/sdadc_seq.v
// Delta-sigma conversion sequencer: mode control, decimator priming, end-of-conversion and APB registers.
// Assumes one 25 MHz clock, synchronous inputs and a modulator bitstream sampled once per clock.
//
// Function
// (R1) Selectable single, multi, continuous, turbo modes; the code runs turbo exactly as multi
// (R2) Start by software bit or external input
// (R3) Completion sets flag, end output until read
// (R4) Single mode idles in standby until start
// (R5) Single trigger: three priming plus one conversion
// (R6) After single result read, return to standby
// (R7) Continuous: three priming, then one per period
// (R8) Other side keeps mux fixed in continuous
// (R9) Multi mode re-primes decimator between samples
// (R10) Multi mode restarts automatically after completion
// (R11) Output from last four samples; mux invalidates
// (R12) 12 bits at 192k or 8 at 384k
// (R13) End output rises at every conversion end
// (R14) Start input may be clock or logic
// (R15) Software may poll status instead of interrupt
// (R16) Start ignored while single sequence busy
// (R17) Result read clears flag and end output
//
// Decided for this implementation: the address map and the APB interface to the registers.
`include "sdadc_map.vh"

module sdadc_seq #(
  parameter PER12_CYC = `SDADC_PER12_CYC,
  parameter PER8_CYC  = `SDADC_PER8_CYC
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_nrst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // Converter side
  input  wire        i_mod_bit,
  input  wire        i_start_conv,
  input  wire        i_mux_change,
  input  wire        i_dma_read,
  // Events
  output reg         o_end_conv,
  output reg         o_irq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_PRIME = 2'd1;
  localparam ST_CONV  = 2'd2;
  localparam ST_HOLD  = 2'd3;

  reg  [4:0]  ctrl;
  reg  [1:0]  state;
  reg  [8:0]  cyc;
  reg  [1:0]  prime_cnt;
  reg  [11:0] acc [0:3];
  reg  [11:0] cur;
  reg  [11:0] result;
  reg         done;
  reg  [1:0]  irq_stat;
  reg  [1:0]  irq_en;
  reg         start_q;

  wire        setup    = i_psel & ~i_penable;
  wire        wr       = setup & i_pwrite;
  wire        rd       = setup & ~i_pwrite;
  wire [1:0]  mode     = ctrl[`SDADC_CTRL_MODE_HI:`SDADC_CTRL_MODE_LO];
  wire        res8     = ctrl[`SDADC_CTRL_RES8];
  wire [8:0]  period   = res8 ? PER8_CYC[8:0] : PER12_CYC[8:0];           // [R12]
  wire        sw_start = wr & (i_paddr == `SDADC_OFF_CTRL) & i_pwdata[`SDADC_CTRL_START];
  // Enable as it stands after this edge, so a write of enable plus start starts at once
  wire        en_next  = (wr && i_paddr == `SDADC_OFF_CTRL) ? i_pwdata[`SDADC_CTRL_ENABLE] : ctrl[`SDADC_CTRL_ENABLE];
  wire        start    = en_next & (sw_start | (i_start_conv & ~start_q)); // [R2]
  wire        res_read = (rd & (i_paddr == `SDADC_OFF_RESULT)) | i_dma_read;
  wire        conv_end = (state == ST_PRIME || state == ST_CONV) && (cyc == period - 9'd1);
  wire        final_ev = conv_end && (state == ST_CONV || prime_cnt == `SDADC_PRIME_CONV); // [R5]
  // Ones of the closing period, last bit included, so each period counts all its bits
  wire [11:0] conv_cnt = cur + {11'h000, i_mod_bit};
  wire [11:0] sum4     = acc[0] + acc[1] + acc[2] + conv_cnt;              // [R11]
  wire [11:0] sample   = res8 ? {4'h0, sum4[11:4]} : sum4;
  wire        addr_ok  = (i_paddr[11:5] == 7'h00) && (i_paddr[4:0] <= 5'h14) && (i_paddr[1:0] == 2'b00);
  wire [1:0]  next_irq = irq_stat | {final_ev & done, final_ev};
  wire        irq_clr  = wr & (i_paddr == `SDADC_OFF_IRQ_CLR);
  integer     k;

  // Sequencer
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state     <= ST_IDLE;
      cyc       <= 9'h000;
      prime_cnt <= 2'h0;
      cur       <= 12'h000;
      start_q   <= 1'b0;
      for (k = 0; k < 4; k = k + 1)
        acc[k] <= 12'h000;
    end else begin
      start_q <= i_start_conv;
      if (state == ST_PRIME || state == ST_CONV) begin
        cyc <= (cyc == period - 9'd1) ? 9'h000 : cyc + 9'd1;
        cur <= (cyc == period - 9'd1) ? 12'h000 : cur + {11'h000, i_mod_bit};
      end
      if (conv_end) begin
        acc[0] <= conv_cnt;                                                 // [R11]
        for (k = 1; k < 4; k = k + 1)
          acc[k] <= acc[k-1];
      end
      if (i_mux_change) begin
        prime_cnt <= 2'h0;                                                  // [R11]
        if (state == ST_CONV)
          state <= ST_PRIME;
      end
      case (state)
        ST_IDLE: begin
          // Starts are only taken here, so a start never restarts priming of a busy sequence
          if (start) begin                                                  // [R4] [R16]
            state     <= ST_PRIME;
            cyc       <= 9'h000;
            cur       <= 12'h000;
            prime_cnt <= 2'h0;
          end
        end
        ST_PRIME: begin
          if (conv_end && !i_mux_change) begin
            if (prime_cnt == `SDADC_PRIME_CONV)
              state <= (mode == `SDADC_MODE_SINGLE) ? ST_HOLD : (mode == `SDADC_MODE_CONT) ? ST_CONV : ST_PRIME; // [R5] [R7]
            prime_cnt <= (prime_cnt == `SDADC_PRIME_CONV) ? 2'h0 : prime_cnt + 2'd1; // [R9] [R10]
          end
        end
        ST_CONV: begin
          if (!ctrl[`SDADC_CTRL_ENABLE] || mode != `SDADC_MODE_CONT)        // [R7]
            state <= ST_IDLE;
        end
        ST_HOLD: begin
          if (res_read || !done)                                            // [R6]
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      // Disabling aborts a run, but an unread single result is kept
      if (!en_next && state != ST_HOLD)
        state <= ST_IDLE;
    end
  end

  // Result, done flag, end output
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      result     <= 12'h000;
      done       <= 1'b0;
      o_end_conv <= 1'b0;
    end else begin
      if (final_ev) begin
        result     <= sample;
        done       <= 1'b1;                                                 // [R3]
        o_end_conv <= 1'b1;                                                 // [R13]
      end else if (res_read) begin
        done       <= 1'b0;                                                 // [R17]
        o_end_conv <= 1'b0;                                                 // [R17]
      end
    end
  end

  // APB registers, zero wait state: pready in the access cycle
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl      <= `SDADC_CTRL_RST;
      irq_stat  <= 2'h0;
      irq_en    <= 2'h0;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & ~addr_ok;
      if (wr && i_paddr == `SDADC_OFF_CTRL)
        ctrl <= {i_pwdata[4:1], 1'b0};                                      // [R1]
      if (wr && i_paddr == `SDADC_OFF_IRQ_EN)
        irq_en <= i_pwdata[1:0];
      // Set wins over a simultaneous clear
      irq_stat <= next_irq & ~(irq_clr ? i_pwdata[1:0] & ~{final_ev & done, final_ev} : 2'h0);
      o_irq    <= |(next_irq & irq_en);
      if (rd) begin
        case (i_paddr)
          `SDADC_OFF_CTRL:     o_prdata <= {27'h0, ctrl};
          `SDADC_OFF_STATUS:   o_prdata <= {29'h0, state == ST_CONV, state != ST_IDLE, done}; // [R15]
          `SDADC_OFF_RESULT:   o_prdata <= {20'h0, result};
          `SDADC_OFF_IRQ_STAT: o_prdata <= {30'h0, irq_stat};
          `SDADC_OFF_IRQ_EN:   o_prdata <= {30'h0, irq_en};
          default:             o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // sdadc_seq

//--- core/sdadc_map.vh
// Register map, field positions, reset values and timing counts of the delta-sigma conversion sequencer.
// Included by the sequencer core; byte addresses on a 32-bit APB bus.
`ifndef SDADC_MAP_VH
`define SDADC_MAP_VH

`define SDADC_OFF_CTRL      12'h000
`define SDADC_OFF_STATUS    12'h004
`define SDADC_OFF_RESULT    12'h008
`define SDADC_OFF_IRQ_STAT  12'h00C
`define SDADC_OFF_IRQ_CLR   12'h010
`define SDADC_OFF_IRQ_EN    12'h014

// Control register fields
`define SDADC_CTRL_START    0
`define SDADC_CTRL_MODE_LO  1
`define SDADC_CTRL_MODE_HI  2
`define SDADC_CTRL_RES8     3
`define SDADC_CTRL_ENABLE   4
`define SDADC_CTRL_RST      5'h00

// Operating modes
`define SDADC_MODE_SINGLE   2'h0
`define SDADC_MODE_MULTI    2'h1
`define SDADC_MODE_CONT     2'h2
`define SDADC_MODE_TURBO    2'h3

// Status register fields
`define SDADC_ST_DONE       0
`define SDADC_ST_BUSY       1
`define SDADC_ST_PRIMED     2

// Interrupt event bits
`define SDADC_IRQ_EOC       0
`define SDADC_IRQ_OVR       1
`define SDADC_IRQ_W         2

// Priming: output is a function of the bit counts of the last four conversion periods
`define SDADC_PRIME_CONV    3

// Sample rates at the 25 MHz clock
`define SDADC_CLK_HZ        25000000
`define SDADC_RATE12_SPS    192000
`define SDADC_RATE8_SPS     384000
`define SDADC_PER12_CYC     ((`SDADC_CLK_HZ + `SDADC_RATE12_SPS - 1) / `SDADC_RATE12_SPS)
`define SDADC_PER8_CYC      ((`SDADC_CLK_HZ + `SDADC_RATE8_SPS - 1) / `SDADC_RATE8_SPS)

`define SDADC_RES12_BITS    12
`define SDADC_RES8_BITS     8

`endif

//--- verif/sdadc_partner.sv
// Far-side model: modulator bitstream, external start source and DMA reader.
// Assumes the sequencer's clock; every output changes just after a rising edge.
module sdadc_partner (
  // Clock
  input  wire logic i_clk,
  // Bench controls
  input  wire logic i_level,
  input  wire logic i_go,
  input  wire logic i_dma_en,
  // From the sequencer
  input  wire logic i_end_conv,
  // To the sequencer
  output logic      o_mod_bit,
  output logic      o_start_conv,
  output logic      o_dma_read
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_mod_bit, o_start_conv, o_dma_read} = 3'b000;
  always @(posedge i_clk) begin
    // Constant stream keeps the expected sum independent of window alignment
    o_mod_bit    <= i_level;
    o_start_conv <= i_go;
    // One pulse per result; the end flag drops the cycle after
    o_dma_read   <= i_dma_en && i_end_conv && !o_dma_read;
  end
endmodule // sdadc_partner

//--- verif/sdadc_seq_chk.sv
// Port checker for the conversion sequencer: APB answer timing and end-of-conversion behaviour.
// Assumes the sequencer's ports only; bound to every instance below.
`include "sdadc_map.vh"
module sdadc_chk #(parameter int PER12_CYC = 8) (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_dma_read,
  input wire logic        o_end_conv,
  input wire logic        o_irq
);
  localparam int T_LO = 4 * PER12_CYC - 1;
  localparam int T_HI = 4 * PER12_CYC + 3;
  wire setup  = i_psel && !i_penable;
  wire rd_res = setup && !i_pwrite && i_paddr == `SDADC_OFF_RESULT;
  // Only a single 12-bit start with the end output low counts; starts while a result is unread are ignored
  wire sw_go  = setup && i_pwrite && i_paddr == `SDADC_OFF_CTRL && i_pwdata[4:0] == 5'h11 && !o_end_conv;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  a_ready_next: assert property (setup |=> o_pready && $past(setup)) else $error("no ready after setup");
  a_err_ready: assert property (o_pslverr |-> o_pready) else $error("slave error without ready");
  a_eoc_hold: assert property (o_end_conv && !rd_res && !i_dma_read |=> o_end_conv)
    else $error("end of conversion dropped unread");
  a_read_clear: assert property (rd_res && o_end_conv |=> !o_end_conv) else $error("read left end set");
  a_dma_clear: assert property (i_dma_read && o_end_conv |=> !o_end_conv) else $error("dma read kept end");
  a_prime_quiet: assert property (sw_go |=> !o_end_conv [*8]) else $error("result before priming");
  a_eoc_latency: assert property (sw_go |-> ##[T_LO:T_HI] o_end_conv) else $error("single result late");
  a_reset_quiet: assert property ($rose(i_nrst) |-> !o_end_conv && !o_irq && !o_pready)
    else $error("outputs active after reset");
  c_eoc: cover property ($rose(o_end_conv));
  c_err: cover property (o_pslverr);
  c_dma: cover property (i_dma_read && o_end_conv);
endmodule // sdadc_chk
bind sdadc_seq sdadc_chk #(.PER12_CYC(PER12_CYC)) u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_dma_read(i_dma_read), .o_end_conv(o_end_conv), .o_irq(o_irq));

//--- verif/testbench.sv
// Self-checking bench for the conversion sequencer: APB master, far-side model, latency and result model.
// Assumes short period parameters; the port checker is bound on its own.
`include "sdadc_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P  = 8;
  localparam int P8 = 4;
  logic        i_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
  logic        level = 0, go = 0, dma_en = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, rd;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, o_end_conv, o_irq, mod_bit, start_conv, dma_read;
  int          n_errors = 0, checked = 0, n, gap;
  always #20 i_clk = ~i_clk;
  sdadc_seq #(.PER12_CYC(P), .PER8_CYC(P8)) DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mod_bit(mod_bit), .i_start_conv(start_conv),
    .i_mux_change(1'b0), .i_dma_read(dma_read), .o_end_conv(o_end_conv), .o_irq(o_irq));
  sdadc_partner u_far (.i_clk(i_clk), .i_level(level), .i_go(go), .i_dma_en(dma_en), .i_end_conv(o_end_conv),
    .o_mod_bit(mod_bit), .o_start_conv(start_conv), .o_dma_read(dma_read));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    {i_psel, i_penable, i_pwrite} <= {2'b10, w};
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    chk(o_pready, 1);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
    @(posedge i_clk);
  endtask
  task weoc();
    n = 0;
    while (o_end_conv !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_end_conv, 1);
  endtask
  task stop_test();
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h3c42cc7f));
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    apb(0, 12'h018, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    level <= 1'($urandom);
    apb(1, `SDADC_OFF_IRQ_EN, 32'h0000_0001);
    apb(1, `SDADC_OFF_CTRL, 32'h0000_0011);
    go <= 1'b1;
    weoc();
    chk(n >= 4 * P - 3 && n <= 4 * P + 2, 1);
    repeat (2) @(posedge i_clk);
    chk(o_irq, 1);
    apb(0, `SDADC_OFF_STATUS, 32'h0000_0000);
    chk(rd[`SDADC_ST_DONE], 1);
    apb(0, `SDADC_OFF_RESULT, 32'h0000_0000);
    chk(rd, level ? 4 * P : 0);
    chk(o_end_conv, 0);
    go <= 1'b0;
    repeat (5 * P) @(posedge i_clk);
    chk(o_end_conv, 0);
    apb(1, `SDADC_OFF_IRQ_CLR, 32'h0000_0001);
    apb(1, `SDADC_OFF_IRQ_EN, 32'h0000_0000);
    chk(o_irq, 0);
    $display("test single done");
    apb(1, `SDADC_OFF_CTRL, 32'h0000_0010);
    go <= 1'b1;
    dma_en <= 1'b1;
    weoc();
    chk(n >= 4 * P - 2 && n <= 4 * P + 4, 1);
    repeat (3) @(posedge i_clk);
    chk({o_end_conv, o_irq}, 0);
    {go, dma_en} <= 2'b00;
    $display("test external start done");
    for (int m = 1; m < 4; m++) begin
      apb(1, `SDADC_OFF_CTRL, 32'h0000_0011 | (m << 1));
      weoc();
      chk(n >= 4 * P - 3 && n <= 4 * P + 2, 1);
      apb(0, `SDADC_OFF_RESULT, 32'h0000_0000);
      weoc();
      gap = n + 2;
      chk(m == 2 ? gap >= P - 2 && gap <= P + 2 : gap >= 4 * P - 2 && gap <= 4 * P + 3, 1);
      apb(0, `SDADC_OFF_RESULT, 32'h0000_0000);
      apb(1, `SDADC_OFF_CTRL, 32'h0000_0000);
    end
    $display("test modes done");
    apb(1, `SDADC_OFF_CTRL, 32'h0000_0019);
    weoc();
    chk(n >= 4 * P8 - 3 && n <= 4 * P8 + 2, 1);
    apb(0, `SDADC_OFF_RESULT, 32'h0000_0000);
    chk(rd[31:8], 0);
    $display("test eight bit done");
    stop_test();
  end
endmodule // testbench
